// ### hw/cdtx_regs.vh
// Register map, field positions and reset values of the CAN timing and filter configuration block.
`ifndef CDTX_REGS_VH
`define CDTX_REGS_VH
`define CDTX_ADDR_W 8
`define CDTX_OFS_DBTP 8'h0c
`define CDTX_OFS_XFC 8'h88
`define CDTX_OFS_CFG 8'h18
`define CDTX_RST_DBTP 32'h00000000
`define CDTX_RST_XFC 32'h00000000
`define CDTX_SJW_LSB 0
`define CDTX_SJW_MSB 3
`define CDTX_DSEG2_LSB 4
`define CDTX_DSEG2_MSB 7
`define CDTX_DSEG1_LSB 8
`define CDTX_DSEG1_MSB 12
`define CDTX_FLS_LSB 0
`define CDTX_FLS_MSB 15
`define CDTX_WORD_LSB 2
`define CDTX_LSIZE_LSB 16
`define CDTX_LSIZE_MSB 22
`define CDTX_LSIZE_MAX 7'h40
`define CDTX_CFG_CCE 0
`define CDTX_CFG_INIT 1
`endif

// ### hw/cdtx_plus_one.v
// Converts a programmed field value into its effective length, one more than programmed.
`timescale 1ns/1ps
module cdtx_plus_one #(
  parameter W = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] val_i,
  output reg [W:0] eff_o
);
  // Registered so that every top-level output comes from a flip-flop.
  always @(posedge clk_i) begin
    if (rst_i) begin
      eff_o <= {{W{1'b0}}, 1'b1};
    end else begin
      eff_o <= {1'b0, val_i} + {{W{1'b0}}, 1'b1};
    end
  end
endmodule // cdtx_plus_one

// ### hw/cdtx_list_size.v
// Clamps the extended filter list size and flags an empty list.
`include "cdtx_regs.vh"
`timescale 1ns/1ps
module cdtx_list_size (
  input wire clk_i,
  input wire rst_i,
  input wire [6:0] size_i,
  output reg [6:0] count_o,
  output reg enable_o
);
  // Sizes above the ceiling count as the ceiling; zero disables the list.
  always @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= 7'h00;
      enable_o <= 1'b0;
    end else begin
      count_o <= (size_i > `CDTX_LSIZE_MAX) ? `CDTX_LSIZE_MAX : size_i;
      enable_o <= (size_i != 7'h00);
    end
  end
endmodule // cdtx_list_size

// ### hw/cdtx_cfg_top.v
// Wishbone register block for CAN data-phase bit timing and extended filter list configuration.
//
// Behaviour
// - The segment before the sample point is a 5-bit field in bits 12:8, used as value plus one.
// - The segment after the sample point is a 4-bit field in bits 7:4, used as value plus one.
// - The resynchronization jump width is a 4-bit field in bits 3:0, used as value plus one.
// - A list size of zero in bits 22:16 means no extended filter element is evaluated.
// - List sizes 1 to 64 are element counts and anything larger is taken as 64.
// - The start address of the extended filter list is a 16-bit field in bits 15:0.
// - Filter elements are fetched from message RAM in whole 32-bit words only.
// - Only start address bits 15 to 2 form the word address; the two lowest bits are ignored.
// - The two lowest start address bits always read back as zero.
//
// The Wishbone interface to the registers was decided locally.
`include "cdtx_regs.vh"
`timescale 1ns/1ps
module cdtx_cfg_top (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [`CDTX_ADDR_W-1:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output wire [5:0] data_seg_before_sample_o,
  output wire [4:0] data_seg_after_sample_o,
  output wire [4:0] data_resync_jump_width_o,
  output wire [6:0] ext_filter_list_size_o,
  output wire ext_filter_enable_o,
  output reg [13:0] ext_filter_word_addr_o,
  output reg cfg_change_en_o
);
  reg [12:0] dbtp_q;
  reg [22:0] xfc_q;
  reg [1:0] cfg_q;
  wire req;
  wire wr;
  wire [31:0] wmask;
  wire [31:0] dbtp_full;
  wire [31:0] xfc_full;
  wire [31:0] cfg_full;
  wire [31:0] dbtp_new;
  wire [31:0] xfc_new;
  wire [31:0] cfg_new;
  reg [31:0] rdata;

  // A new request is one not yet answered; ack drops the cycle after it rises.
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign dbtp_full = {19'h00000, dbtp_q};
  assign xfc_full = {9'h000, xfc_q};
  assign cfg_full = {30'h00000000, cfg_q};
  assign dbtp_new = (dbtp_full & ~wmask) | (dat_i & wmask);
  assign xfc_new = (xfc_full & ~wmask) | (dat_i & wmask);
  assign cfg_new = (cfg_full & ~wmask) | (dat_i & wmask);

  // Byte-lane writes; timing and filter registers are locked outside configuration change.
  always @(posedge clk_i) begin
    if (rst_i) begin
      dbtp_q <= 13'h0000;
      xfc_q <= 23'h000000;
      cfg_q <= 2'h0;
    end else if (wr) begin
      if (adr_i == `CDTX_OFS_CFG) begin
        cfg_q <= cfg_new[1:0];
      end else if (adr_i == `CDTX_OFS_DBTP && cfg_q[`CDTX_CFG_CCE] && cfg_q[`CDTX_CFG_INIT]) begin
        dbtp_q <= dbtp_new[12:0];
      end else if (adr_i == `CDTX_OFS_XFC && cfg_q[`CDTX_CFG_CCE] && cfg_q[`CDTX_CFG_INIT]) begin
        xfc_q <= {xfc_new[`CDTX_LSIZE_MSB:`CDTX_LSIZE_LSB],
                  xfc_new[`CDTX_FLS_MSB:`CDTX_WORD_LSB], 2'b00};
      end
    end
  end

  // Read decode; unmapped addresses read zero and are still acknowledged.
  always @* begin
    if (adr_i == `CDTX_OFS_DBTP) begin
      rdata = dbtp_full;
    end else if (adr_i == `CDTX_OFS_XFC) begin
      rdata = xfc_full;
    end else if (adr_i == `CDTX_OFS_CFG) begin
      rdata = cfg_full;
    end else begin
      rdata = 32'h00000000;
    end
  end

  // Single-cycle acknowledge with registered read data.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req;
      dat_o <= req ? rdata : 32'h00000000;
    end
  end

  // Word address toward message RAM and configuration-change state output.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_filter_word_addr_o <= 14'h0000;
      cfg_change_en_o <= 1'b0;
    end else begin
      ext_filter_word_addr_o <= xfc_q[`CDTX_FLS_MSB:`CDTX_WORD_LSB];
      cfg_change_en_o <= cfg_q[`CDTX_CFG_CCE] & cfg_q[`CDTX_CFG_INIT];
    end
  end

  // Effective segment lengths and jump width, each one above the programmed value.
  cdtx_plus_one #(.W(5)) u_seg1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .val_i(dbtp_q[`CDTX_DSEG1_MSB:`CDTX_DSEG1_LSB]),
    .eff_o(data_seg_before_sample_o)
  );
  cdtx_plus_one #(.W(4)) u_seg2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .val_i(dbtp_q[`CDTX_DSEG2_MSB:`CDTX_DSEG2_LSB]),
    .eff_o(data_seg_after_sample_o)
  );
  cdtx_plus_one #(.W(4)) u_sjw (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .val_i(dbtp_q[`CDTX_SJW_MSB:`CDTX_SJW_LSB]),
    .eff_o(data_resync_jump_width_o)
  );

  // Clamped extended list size and list enable.
  cdtx_list_size u_lse (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .size_i(xfc_q[`CDTX_LSIZE_MSB:`CDTX_LSIZE_LSB]),
    .count_o(ext_filter_list_size_o),
    .enable_o(ext_filter_enable_o)
  );
endmodule // cdtx_cfg_top

// ### tb/cdtx_filter_sink.sv
// Far-side filter fetch model.
`timescale 1ns/1ps
module cdtx_filter_sink (
  input logic enable_i,
  input logic [13:0] word_addr_i,
  output logic [15:0] fetch_adr_o
);
  // Fetches whole words only, so the byte address has its low bits clear.
  assign fetch_adr_o = enable_i ? {word_addr_i, 2'h0} : 16'h0;
endmodule // cdtx_filter_sink

// ### tb/cdtx_checker.sv
// Assertions on the bus answer and the configuration outputs.
`timescale 1ns/1ps
module cdtx_checker (
  input logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, ext_filter_enable_o, cfg_change_en_o,
  input logic [7:0] adr_i,
  input logic [31:0] dat_o,
  input logic [5:0] data_seg_before_sample_o,
  input logic [4:0] data_seg_after_sample_o, data_resync_jump_width_o,
  input logic [6:0] ext_filter_list_size_o,
  input logic [13:0] ext_filter_word_addr_o
);
  // All checks use the module clock and pause in reset.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack late or held");
  a_seg_before: assert property (data_seg_before_sample_o inside {[6'h01:6'h20]})
    else $error("bad segment before");
  a_seg_after: assert property (data_seg_after_sample_o inside {[5'h01:5'h10]})
    else $error("bad segment after");
  a_jump_width: assert property (data_resync_jump_width_o inside {[5'h01:5'h10]})
    else $error("bad jump width");
  a_empty_list: assert property (ext_filter_enable_o == (ext_filter_list_size_o != 7'h0))
    else $error("bad filter enable");
  a_size_clamp: assert property (ext_filter_list_size_o <= 7'h40)
    else $error("size not clamped");
  a_start_low: assert property (ack_o && !$past(we_i) && $past(adr_i) == 8'h88
    |-> dat_o[1:0] == 2'h0)
    else $error("start low bits set");
  a_locked_write: assert property (cyc_i && stb_i && we_i && !ack_o && adr_i == 8'h88
    && !cfg_change_en_o |=> $stable(ext_filter_word_addr_o) [*3]) else $error("locked write");
endmodule // cdtx_checker
bind cdtx_cfg_top cdtx_checker u_cdtx_checker (.*);

// ### tb/can_data_timing_ext_filter_cfg_test.sv
// Self-checking bench for the CAN timing and filter configuration block.
`timescale 1ns/1ps
module can_data_timing_ext_filter_cfg_test;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic ack_o, ext_filter_enable_o, cfg_change_en_o;
  logic [7:0] adr_i = 8'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rdat;
  logic [5:0] data_seg_before_sample_o;
  logic [4:0] data_seg_after_sample_o, data_resync_jump_width_o;
  logic [6:0] ext_filter_list_size_o;
  logic [13:0] ext_filter_word_addr_o;
  logic [15:0] fetch_adr_o;
  logic [6:0] sz [5] = '{7'h00, 7'h01, 7'h40, 7'h41, 7'h7f};
  int num_errors = 0, compares = 0, cycles = 0;
  cdtx_cfg_top u_cdtx_cfg_top (.*);
  cdtx_filter_sink u_cdtx_filter_sink (
    .enable_i(ext_filter_enable_o),
    .word_addr_i(ext_filter_word_addr_o),
    .fetch_adr_o(fetch_adr_o)
  );
  // Clock and hang guard.
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      summarize;
    end
  end
  task summarize;
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  // One classic bus cycle; read data is taken at the acknowledging edge.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, 4'hf, d};
    @(posedge clk_i);
    while (ack_o !== 1'h1) @(posedge clk_i);
    rdat = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
    repeat (2) @(posedge clk_i);
  endtask
  // Main sequence.
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    xfer(1'h0, 8'h0c, 32'h0);
    chk(rdat, 32'h0);
    chk({data_seg_before_sample_o, data_seg_after_sample_o, data_resync_jump_width_o},
        16'h0421);
    xfer(1'h1, 8'h88, 32'h00410104);
    xfer(1'h0, 8'h88, 32'h0);
    chk(rdat, 32'h0);
    chk({31'h0, cfg_change_en_o}, 32'h0);
    xfer(1'h1, 8'h18, 32'h3);
    chk({31'h0, cfg_change_en_o}, 32'h1);
    xfer(1'h1, 8'h0c, 32'hffffffff);
    xfer(1'h0, 8'h0c, 32'h0);
    chk(rdat, 32'h1fff);
    chk({data_seg_before_sample_o, data_seg_after_sample_o, data_resync_jump_width_o},
        16'h8210);
    for (int i = 0; i < 5; i++) begin
      xfer(1'h1, 8'h88, {9'h0, sz[i], 16'h0107});
      xfer(1'h0, 8'h88, 32'h0);
      chk(rdat, {9'h0, sz[i], 16'h0104});
      chk({ext_filter_enable_o, ext_filter_list_size_o},
          {sz[i] != 7'h0, sz[i] > 7'h40 ? 7'h40 : sz[i]});
      chk({ext_filter_word_addr_o, fetch_adr_o},
          {14'h41, sz[i] != 7'h0 ? 16'h0104 : 16'h0});
    end
    xfer(1'h1, 8'h40, 32'hffffffff);
    xfer(1'h0, 8'h40, 32'h0);
    chk(rdat, 32'h0);
    xfer(1'h1, 8'h18, 32'h1);
    chk({31'h0, cfg_change_en_o}, 32'h0);
    xfer(1'h1, 8'h88, 32'h0);
    xfer(1'h0, 8'h88, 32'h0);
    chk(rdat, 32'h007f0104);
    xfer(1'h1, 8'h0c, 32'h0);
    xfer(1'h0, 8'h0c, 32'h0);
    chk(rdat, 32'h1fff);
    summarize;
  end
endmodule // can_data_timing_ext_filter_cfg_test
